/* File: verilog/pcm_pkg.sv */
// Constants for the pulse counter and measurement block.
// Assumes a 100 MHz clock and AXI4-Lite register access.
package pcm_pkg;
    localparam int CLK_HZ = 100000000;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MAIN_SCALE = 8'h04;
    localparam logic [7:0] REG_MAIN_WRAP = 8'h08;
    localparam logic [7:0] REG_SEC_SCALE = 8'h0c;
    localparam logic [7:0] REG_SEC_WRAP = 8'h10;
    localparam logic [7:0] REG_MIN_LOW = 8'h14;
    localparam logic [7:0] REG_MIN_HIGH = 8'h18;
    localparam logic [7:0] REG_MAIN_CNT = 8'h1c;
    localparam logic [7:0] REG_SEC_CNT = 8'h20;
    localparam logic [7:0] REG_RESULT = 8'h24;
    localparam logic [7:0] REG_PASS = 8'h28;
    localparam logic [7:0] REG_TIME = 8'h2c;
    localparam logic [7:0] REG_SVC = 8'h30;
    localparam logic [7:0] REG_STATUS = 8'h34;
    // Control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RST_MAIN = 4;
    localparam int CTRL_RST_SEC = 5;
    // Service fields (write-only pulses)
    localparam int SVC_RESTORE = 0;
    localparam int SVC_TEST = 1;
    localparam int SVC_KEY = 2;
    // Modes
    localparam logic [3:0] MODE_CNT = 4'h0;
    localparam logic [3:0] MODE_FLO = 4'h1;
    localparam logic [3:0] MODE_FHI = 4'h2;
    localparam logic [3:0] MODE_SPD = 4'h3;
    localparam logic [3:0] MODE_PSH = 4'h4;
    localparam logic [3:0] MODE_PLG = 4'h5;
    localparam logic [3:0] MODE_WORK = 4'h6;
    localparam logic [3:0] MODE_ENC = 4'h7;
    localparam logic [3:0] MODE_TIME = 4'h8;
    // Defaults
    localparam logic [31:0] DEF_SCALE = 32'h00000001;
    localparam logic [31:0] DEF_WRAP = 32'h0001869f;
    localparam logic [31:0] DEF_MIN = 32'h00000000;
    localparam logic [31:0] PASS_MAX = 32'h0000ea60;
    localparam logic [31:0] HOUR_MAX = 32'h00000017;
    localparam logic [31:0] MIN_MAX = 32'h0000003b;
    // Minimum pulse times in microseconds
    localparam logic [31:0] MIN_CHK_US = 32'h000000fa;
    localparam logic [31:0] MIN_CHK2_US = 32'h00001388;
    // Window limits in units of 0.1 s
    localparam logic [31:0] WIN_MIN = 32'h00000005;
    localparam logic [31:0] WIN_MAX_F = 32'h000000c8;
    localparam logic [31:0] WIN_MAX_PS = 32'h0000006e;
    localparam logic [31:0] WIN_MAX_PL = 32'h00008ca0;
    localparam int TICK_US_NS = 1000;
    localparam int TICK_US_CYC = TICK_US_NS / 10;
    localparam int TENTH_S_US = 100000;
    localparam int TEST_STEP_MS = 100;
    localparam int TEST_STEP_CYC = TEST_STEP_MS * 100000;
endpackage

/* File: verilog/pcm_top.sv */
// Pulse counter and measurement logic behind an AXI4-Lite slave.
// Assumes pulse pins are asynchronous and synchronised here.
// Behaviour
// R1: Rising count clears past wrap limit
// R2: Falling count through zero loads limit
// R3: Direction input only in counter/encoder
// R4: Second input counts only, own settings
// R5: Encoder counts up at level 1
// R6: Negative main constant reverses direction
// R7: Negative constant makes worktime count down
// R8: Source holds main input for worktime
// R9: Minimum pulse check above threshold only
// R10: Out-of-range limit gives longest window
// R11: Window bounded per measuring mode
// R12: Reset value from constant and limit signs
// R13: Restore loads defaults, no keeps all
// R14: Passcode up to 60000, zero disables
// R15: Invalid time entry discarded
// R16: Display test steps until key press
// R17: Result updated once per window
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module pcm_top
    import pcm_pkg::*;
#(
    parameter int TICK_TENTH_CYC = TENTH_S_US * TICK_US_CYC,
    parameter int TEST_CYC = TEST_STEP_CYC
) (
    input wire logic clk, // Clock
    input wire logic nrst, // Async reset, active low
    input wire logic main_pulse_input, // Main pulse pin
    input wire logic main_direction_input, // Direction pin
    input wire logic second_count_input, // Second counter pin
    input wire logic [31:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [31:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready, // Read ready
    output logic [6:0] test_segment, // Display test segment one-hot
    output logic test_leds // Alarm and unit lamps during test
);
    logic [2:0] s1_ff, s2_ff;
    logic p_ff, d_ff, q_ff, p_d_ff, d_d_ff, q_d_ff;
    logic [3:0] mode_ff;
    logic [31:0] ms_ff, mw_ff, ss_ff, sw_ff, tl_ff, th_ff;
    logic [31:0] mc_ff, sc_ff, res_ff, pass_ff, pass_en_ff, time_ff;
    logic [31:0] acc_ff, win_ff, tick_ff, tus_ff, lo_ff, hi_ff;
    logic [31:0] pw_ff, test_cnt_ff, nxt_mc, nxt_sc;
    logic aw_ok_ff, w_ok_ff, bad_ff;
    logic [7:0] aw_ff;
    logic [31:0] wd_ff;
    logic test_ff, pulse_ok;
    logic [6:0] seg_ff;
    logic rst_main, rst_sec, win_end, main_rise, sec_rise, step_up;
    logic [31:0] win_lim, win_len;
    logic [31:0] us_cyc;

    // Signed step of a wrapping counter
    function automatic logic [31:0] wrap_step(input logic [31:0] c,
            input logic up, input logic [31:0] lim);
        logic [31:0] r;
        r = c;
        if (up) begin
            r = c + 32'h1;
            if ($signed(lim) > 0 && $signed(r) > $signed(lim)) begin // R1
                r = 32'h0;
            end
        end else begin
            r = c - 32'h1;
            if ($signed(c) >= 0 && $signed(r) < 0) begin // R2
                r = lim;
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] reset_val(input logic [31:0] k,
            input logic [31:0] lim);
        logic [31:0] r;
        r = lim;
        if ($signed(k) > 0 && $signed(lim) >= 0) begin // R12
            r = 32'h0;
        end else if ($signed(k) < 0 && $signed(lim) <= 0) begin // R12
            r = 32'h0;
        end
        return r;
    endfunction

    // Two-flop synchronisers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_ff <= 3'h0;
            s2_ff <= 3'h0;
        end else begin
            s1_ff <= {second_count_input, main_direction_input,
                main_pulse_input};
            s2_ff <= s1_ff;
        end
    end
    assign p_ff = s2_ff[0];
    assign d_ff = s2_ff[1];
    assign q_ff = s2_ff[2];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p_d_ff <= 1'b0;
            d_d_ff <= 1'b0;
            q_d_ff <= 1'b0;
        end else begin
            p_d_ff <= p_ff;
            d_d_ff <= d_ff;
            q_d_ff <= q_ff;
        end
    end
    assign main_rise = p_ff && !p_d_ff;
    assign sec_rise = q_ff && !q_d_ff;

    // Microsecond tick and pulse width tracking
    assign us_cyc = 32'(TICK_US_CYC);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tus_ff <= 32'h0;
            lo_ff <= 32'h0;
            hi_ff <= 32'h0;
            pw_ff <= 32'h0;
        end else begin
            tus_ff <= (tus_ff >= us_cyc - 32'h1) ? 32'h0 : tus_ff + 32'h1;
            if (p_ff != p_d_ff) begin
                pw_ff <= 32'h0;
                if (p_d_ff) begin
                    hi_ff <= pw_ff;
                end else begin
                    lo_ff <= pw_ff;
                end
            end else if (tus_ff == 32'h0 && pw_ff != 32'hffffffff) begin
                pw_ff <= pw_ff + 32'h1;
            end
        end
    end

    // R9: check widths only when both minimums reach the threshold
    always_comb begin
        logic [31:0] thr;
        thr = (mode_ff == MODE_FLO || mode_ff == MODE_SPD) ?
            MIN_CHK2_US : MIN_CHK_US;
        pulse_ok = 1'b1;
        if (tl_ff >= thr && th_ff >= thr) begin // R9
            pulse_ok = (lo_ff >= tl_ff) && (hi_ff >= th_ff);
        end
    end

    // R3 R5 R6: main count direction
    always_comb begin
        logic up;
        up = 1'b1;
        if (mode_ff == MODE_ENC) begin
            up = d_ff; // R5
        end
        if ($signed(ms_ff) < 0) begin
            up = !up; // R6 R7
        end
        step_up = up;
    end

    assign rst_main = aw_ok_ff && w_ok_ff && aw_ff == REG_CTRL &&
        wd_ff[CTRL_RST_MAIN];
    assign rst_sec = aw_ok_ff && w_ok_ff && aw_ff == REG_CTRL &&
        wd_ff[CTRL_RST_SEC];

    always_comb begin
        logic dir_rise;
        dir_rise = d_ff && !d_d_ff;
        nxt_mc = mc_ff;
        case (mode_ff)
            MODE_CNT: begin
                if (main_rise && pulse_ok) begin // R3
                    nxt_mc = wrap_step(mc_ff, step_up, mw_ff);
                end
            end
            MODE_ENC: begin
                if (main_rise) begin // R5
                    nxt_mc = wrap_step(mc_ff, step_up, mw_ff);
                end
            end
            MODE_WORK: begin
                if (p_ff && tick_ff == 32'h0) begin // R8 R7
                    nxt_mc = wrap_step(mc_ff, step_up, mw_ff);
                end
            end
            default: begin
                nxt_mc = mc_ff;
            end
        endcase
        if (mode_ff == MODE_CNT && dir_rise) begin // R3
            nxt_mc = wrap_step(nxt_mc, !step_up, mw_ff);
        end
        if (rst_main) begin
            nxt_mc = reset_val(ms_ff, mw_ff); // R12
        end
    end

    always_comb begin
        nxt_sc = sc_ff;
        if (sec_rise) begin // R4
            nxt_sc = wrap_step(sc_ff, $signed(ss_ff) >= 0, sw_ff);
        end
        if (rst_sec) begin
            nxt_sc = reset_val(ss_ff, sw_ff); // R12
        end
    end

    // R10 R11: window length in tenths of a second
    always_comb begin
        win_lim = WIN_MAX_F;
        if (mode_ff == MODE_PSH) begin
            win_lim = WIN_MAX_PS;
        end else if (mode_ff == MODE_PLG) begin
            win_lim = WIN_MAX_PL;
        end
        win_len = mw_ff;
        if ($signed(mw_ff) < $signed(WIN_MIN) ||
                $signed(mw_ff) > $signed(win_lim)) begin // R10 R11
            win_len = win_lim;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_ff <= 32'h0;
        end else begin
            tick_ff <= (tick_ff >= 32'(TICK_TENTH_CYC) - 32'h1) ?
                32'h0 : tick_ff + 32'h1;
        end
    end
    assign win_end = tick_ff == 32'h0 && win_ff + 32'h1 >= win_len;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mc_ff <= 32'h0;
            sc_ff <= 32'h0;
            acc_ff <= 32'h0;
            win_ff <= 32'h0;
            res_ff <= 32'h0;
        end else begin
            mc_ff <= nxt_mc;
            sc_ff <= nxt_sc;
            if (win_end) begin
                res_ff <= acc_ff; // R17
                // A pulse on the window edge opens the next window
                acc_ff <= {31'h0, main_rise && pulse_ok};
                win_ff <= 32'h0;
            end else begin
                if (tick_ff == 32'h0) begin
                    win_ff <= win_ff + 32'h1;
                end
                if (main_rise && pulse_ok) begin
                    acc_ff <= acc_ff + 32'h1;
                end
            end
        end
    end

    // AXI4-Lite write side
    assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_ok_ff && !s_axi_bvalid;
    assign s_axi_bresp = bad_ff ? 2'h2 : 2'h0;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            aw_ff <= 8'h0;
            wd_ff <= 32'h0;
            s_axi_bvalid <= 1'b0;
            bad_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_ff <= 1'b1;
                aw_ff <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_ff <= 1'b1;
                wd_ff <= s_axi_wdata;
            end
            if (aw_ok_ff && w_ok_ff) begin
                aw_ok_ff <= 1'b0;
                w_ok_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                bad_ff <= aw_ff > REG_STATUS || aw_ff[1:0] != 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Parameter registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_ff <= MODE_CNT;
            ms_ff <= DEF_SCALE;
            mw_ff <= DEF_WRAP;
            ss_ff <= DEF_SCALE;
            sw_ff <= DEF_WRAP;
            tl_ff <= DEF_MIN;
            th_ff <= DEF_MIN;
            pass_ff <= 32'h0;
            time_ff <= 32'h0;
        end else if (aw_ok_ff && w_ok_ff) begin
            case (aw_ff)
                REG_CTRL: mode_ff <= wd_ff[CTRL_MODE_LSB +: 4];
                REG_MAIN_SCALE: ms_ff <= wd_ff;
                REG_MAIN_WRAP: mw_ff <= wd_ff;
                REG_SEC_SCALE: ss_ff <= wd_ff;
                REG_SEC_WRAP: sw_ff <= wd_ff;
                REG_MIN_LOW: tl_ff <= wd_ff;
                REG_MIN_HIGH: th_ff <= wd_ff;
                REG_PASS: begin
                    if (wd_ff <= PASS_MAX) begin // R14
                        pass_ff <= wd_ff;
                    end
                end
                REG_TIME: begin
                    if (wd_ff[15:8] <= HOUR_MAX[7:0] &&
                            wd_ff[7:0] <= MIN_MAX[7:0] &&
                            wd_ff[31:16] == 16'h0) begin // R15
                        time_ff <= wd_ff;
                    end
                end
                REG_SVC: begin
                    if (wd_ff[SVC_RESTORE]) begin // R13
                        mode_ff <= MODE_CNT;
                        ms_ff <= DEF_SCALE;
                        mw_ff <= DEF_WRAP;
                        ss_ff <= DEF_SCALE;
                        sw_ff <= DEF_WRAP;
                        tl_ff <= DEF_MIN;
                        th_ff <= DEF_MIN;
                        pass_ff <= 32'h0;
                    end
                end
                default: begin
                    mode_ff <= mode_ff;
                end
            endcase
        end
    end
    assign pass_en_ff = {31'h0, pass_ff != 32'h0}; // R14

    // R16: display test walks segments until a key press
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            test_ff <= 1'b0;
            seg_ff <= 7'h0;
            test_cnt_ff <= 32'h0;
        end else if (aw_ok_ff && w_ok_ff && aw_ff == REG_SVC &&
                wd_ff[SVC_KEY]) begin
            test_ff <= 1'b0; // R16
            seg_ff <= 7'h0;
        end else if (aw_ok_ff && w_ok_ff && aw_ff == REG_SVC &&
                wd_ff[SVC_TEST]) begin
            test_ff <= 1'b1;
            seg_ff <= 7'h01;
            test_cnt_ff <= 32'h0;
        end else if (test_ff) begin
            if (test_cnt_ff >= 32'(TEST_CYC) - 32'h1) begin
                test_cnt_ff <= 32'h0;
                seg_ff <= {seg_ff[5:0], seg_ff[6]}; // R16
            end else begin
                test_cnt_ff <= test_cnt_ff + 32'h1;
            end
        end
    end
    assign test_segment = seg_ff;
    assign test_leds = test_ff;

    // AXI4-Lite read side
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr[7:0])
                REG_CTRL: s_axi_rdata <= {28'h0, mode_ff};
                REG_MAIN_SCALE: s_axi_rdata <= ms_ff;
                REG_MAIN_WRAP: s_axi_rdata <= mw_ff;
                REG_SEC_SCALE: s_axi_rdata <= ss_ff;
                REG_SEC_WRAP: s_axi_rdata <= sw_ff;
                REG_MIN_LOW: s_axi_rdata <= tl_ff;
                REG_MIN_HIGH: s_axi_rdata <= th_ff;
                REG_MAIN_CNT: s_axi_rdata <= mc_ff;
                REG_SEC_CNT: s_axi_rdata <= sc_ff;
                REG_RESULT: s_axi_rdata <= res_ff;
                REG_PASS: s_axi_rdata <= pass_ff;
                REG_TIME: s_axi_rdata <= time_ff;
                REG_SVC: s_axi_rdata <= 32'h0;
                REG_STATUS: s_axi_rdata <= {29'h0, pulse_ok, test_ff,
                    pass_en_ff[0]};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* File: verif/pcm_top_checker.sv */
// Port-level checker for the pulse counter and measurement block.
// Assumes it is bound to pcm_top; one clock, reset active low.
`timescale 1ns/1ps
module pcm_top_checker
    import pcm_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic nrst, // Reset
    input wire logic [31:0] s_axi_awaddr, // AW
    input wire logic s_axi_awvalid, // AW
    input wire logic s_axi_awready, // AW
    input wire logic [31:0] s_axi_wdata, // W
    input wire logic s_axi_wvalid, // W
    input wire logic s_axi_wready, // W
    input wire logic [1:0] s_axi_bresp, // B
    input wire logic s_axi_bvalid, // B
    input wire logic [31:0] s_axi_araddr, // AR
    input wire logic s_axi_arvalid, // AR
    input wire logic s_axi_arready, // AR
    input wire logic [31:0] s_axi_rdata, // R
    input wire logic [1:0] s_axi_rresp, // R
    input wire logic s_axi_rvalid, // R
    input wire logic [6:0] test_segment, // Test segment
    input wire logic test_leds // Test lamps
);
    logic wr_go, ar_go, svc_go, bad_wr;
    assign wr_go = s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready;
    assign ar_go = s_axi_arvalid && s_axi_arready;
    assign svc_go = wr_go && s_axi_awaddr == {24'h0, REG_SVC};
    assign bad_wr = s_axi_awaddr > 32'h34 || s_axi_awaddr[1:0] != 2'h0;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_WR_LAT: assert property (wr_go |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_WR_ERR: assert property (wr_go && bad_wr
        |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h2)
        else $error("bad write not refused");
    AST_BUSY: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    AST_RD_LAT: assert property (ar_go |=> s_axi_rvalid)
        else $error("read data late");
    AST_RD_ERR: assert property (ar_go && s_axi_araddr > 32'h34
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_IDLE_SEG: assert property (!test_leds |-> test_segment == 7'h0)
        else $error("segment lit outside test");
    AST_SEG_HOT: assert property (test_leds |-> $onehot(test_segment))
        else $error("segment not one-hot in test");
    AST_TEST_GO: assert property (svc_go && s_axi_wdata[SVC_TEST]
        && !s_axi_wdata[SVC_KEY] |-> ##[2:4] test_leds)
        else $error("display test did not start");
    AST_TEST_END: assert property (svc_go && s_axi_wdata[SVC_KEY]
        |-> ##[2:4] !test_leds)
        else $error("display test did not end");
endmodule
bind pcm_top pcm_top_checker u_chk (.*);

/* File: verif/pcm_pulse_src.sv */
// Model of the pulse, direction and second count pins.
// Assumes one clock; pins change just after rising edges.
`timescale 1ns/1ps
module pcm_pulse_src (
    input wire logic clk, // Clock
    output logic main_pulse_input, // Main pulse pin
    output logic main_direction_input, // Direction pin
    output logic second_count_input // Second count pin
);
    logic [2:0] pin;
    assign main_pulse_input = pin[0];
    assign main_direction_input = pin[1];
    assign second_count_input = pin[2];
    initial pin = 3'h0;
    // Width w sets high and low time; kept above the synchroniser depth
    task automatic pulse(input int ch, input int n, input int w);
        repeat (n) begin
            @(posedge clk);
            pin[ch] <= 1'b1;
            repeat (w) @(posedge clk);
            pin[ch] <= 1'b0;
            repeat (w - 1) @(posedge clk);
        end
    endtask
    task automatic level(input logic v);
        @(posedge clk);
        pin[1] <= v;
        repeat (4) @(posedge clk);
    endtask
endmodule

/* File: verif/pcm_top_test.sv */
// Self-checking bench for the pulse counter and measurement block.
// Assumes the pin model and the bound checker beside pcm_top.
`timescale 1ns/1ps
module pcm_top_test
    import pcm_pkg::*;
;
    logic clk, nrst;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [6:0] test_segment;
    logic test_leds, main_pulse_input, main_direction_input;
    logic second_count_input;
    logic [33:0] exp_q[$];
    int n_fail, n_tests;
    int unsigned n;

    pcm_top #(.TICK_TENTH_CYC(20), .TEST_CYC(4)) DUT (.*);
    pcm_pulse_src src (.*);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] g);
        logic [33:0] e;
        e = exp_q.size() != 0 ? exp_q.pop_front() : 34'hx;
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t: bus got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_led(input logic e);
        n_tests++;
        if (test_leds !== e) begin
            n_fail++;
            $display("ERROR %0t: test lamps %b", $time, test_leds);
        end
    endtask

    // Results are taken at the falling edge before the handshake edge
    always @(negedge clk) begin
        if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0});
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata});
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r = 2'h0);
        logic aw, w, b;
        exp_q.push_back({r, 32'h0});
        @(posedge clk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r = 2'h0);
        logic ar, v;
        exp_q.push_back({r, d});
        @(posedge clk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (!v);
        s_axi_rready <= 1'b0;
    endtask

    initial begin
        #200000;
        n_fail++;
        stop_test;
    end

    initial begin
        nrst = 1'b0;
        s_axi_awaddr = 32'h0;
        s_axi_wdata = 32'h0;
        s_axi_araddr = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        n = $urandom(65);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(REG_CTRL, 32'h0);
        rd(REG_MAIN_SCALE, DEF_SCALE);
        rd(REG_MAIN_WRAP, DEF_WRAP);
        rd(REG_SEC_CNT, 32'h0);
        rd(8'h40, 32'h0, 2'h2);
        wr(8'h40, 32'h1, 2'h2);
        wr(8'h05, 32'h1, 2'h2);
        wr(REG_MAIN_WRAP, 32'h5);
        src.pulse(0, 3, 4);
        rd(REG_MAIN_CNT, 32'h3);
        src.pulse(1, 1, 4);
        rd(REG_MAIN_CNT, 32'h2);
        src.pulse(0, 4, 6);
        rd(REG_MAIN_CNT, 32'h0);
        src.pulse(1, 1, 4);
        rd(REG_MAIN_CNT, 32'h5);
        wr(REG_MAIN_SCALE, 32'hffffffff);
        src.pulse(0, 1, 4);
        rd(REG_MAIN_CNT, 32'h4);
        wr(REG_CTRL, 32'h10);
        rd(REG_MAIN_CNT, 32'h5);
        wr(REG_MAIN_SCALE, 32'h1);
        wr(REG_CTRL, 32'h17);
        rd(REG_MAIN_CNT, 32'h0);
        src.level(1'b1);
        n = 1 + ($urandom % 4);
        src.pulse(0, n, 5);
        rd(REG_MAIN_CNT, 32'(n));
        src.level(1'b0);
        src.pulse(0, 1, 4);
        rd(REG_MAIN_CNT, 32'(n - 1));
        wr(REG_SEC_WRAP, 32'h3);
        src.pulse(2, 5, 4);
        rd(REG_SEC_CNT, 32'h1);
        wr(REG_MAIN_WRAP, WIN_MIN);
        wr(REG_CTRL, {28'h0, MODE_FLO});
        fork
            src.pulse(0, 40, 5);
        join_none
        repeat (250) @(posedge clk);
        rd(REG_RESULT, 32'ha);
        wr(REG_MAIN_WRAP, 32'h3);
        wait fork;
        repeat (120) @(posedge clk);
        rd(REG_RESULT, 32'ha);
        wr(REG_PASS, PASS_MAX);
        wr(REG_PASS, PASS_MAX + 32'h1);
        rd(REG_PASS, PASS_MAX);
        wr(REG_PASS, 32'h0);
        rd(REG_PASS, 32'h0);
        wr(REG_TIME, 32'h173b);
        wr(REG_TIME, 32'h183b);
        wr(REG_TIME, 32'h173c);
        rd(REG_TIME, 32'h173b);
        wr(REG_SVC, 32'h2);
        repeat (3) @(negedge clk);
        chk_led(1'b1);
        wr(REG_SVC, 32'h4);
        repeat (3) @(negedge clk);
        chk_led(1'b0);
        wr(REG_MAIN_SCALE, 32'hffffffff);
        wr(REG_MAIN_WRAP, 32'h5);
        wr(REG_CTRL, {26'h0, 2'h1, MODE_WORK});
        src.pulse(0, 1, 20);
        rd(REG_MAIN_CNT, 32'h4);
        wr(REG_MAIN_SCALE, 32'h3);
        wr(REG_SVC, 32'h0);
        rd(REG_MAIN_SCALE, 32'h3);
        wr(REG_SVC, 32'h1);
        rd(REG_MAIN_SCALE, DEF_SCALE);
        rd(REG_MAIN_WRAP, DEF_WRAP);
        rd(REG_CTRL, 32'h0);
        wr(REG_MIN_LOW, MIN_CHK_US);
        wr(REG_MIN_HIGH, MIN_CHK_US - 32'h1);
        rd(REG_STATUS, 32'h4);
        wr(REG_MIN_HIGH, MIN_CHK_US);
        rd(REG_STATUS, 32'h0);
        stop_test;
    end
endmodule
